// ===== logic/rbc_pkg.sv
// Purpose: Shared constants and carriers for battery check, century bit and control defaults
// Assumes: 250 MHz i_clk; host bus pins are asynchronous to i_clk
// Notes:   Only the bits named here are stored; other bits read as zero
package rbc_pkg;

  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;

  localparam logic [ADDR_W-1:0] FLAGS_ADDR     = 13'h1ff0;
  localparam logic [ADDR_W-1:0] ALARM_EN_ADDR  = 13'h1ff6;
  localparam logic [ADDR_W-1:0] WATCHDOG_ADDR  = 13'h1ff7;
  localparam logic [ADDR_W-1:0] CONTROL_ADDR   = 13'h1ff8;
  localparam logic [ADDR_W-1:0] CLOCK_CTL_ADDR = 13'h1ffc;

  localparam int BATT_FLAG_BIT   = 4;
  localparam int CENTURY_EN_BIT  = 5;
  localparam int CENTURY_BIT     = 4;
  localparam int FREQ_TEST_BIT   = 6;
  localparam int WRITE_LOCK_BIT  = 7;
  localparam int READ_HOLD_BIT   = 6;
  localparam int ALARM_IRQ_BIT   = 7;
  localparam int ALARM_BKUP_BIT  = 5;
  localparam int WD_STEER_BIT    = 7;
  localparam int WD_MULT_LSB     = 2;
  localparam int WD_RES_LSB      = 0;

  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;

  localparam int CLK_PERIOD_NS  = 4;
  localparam int BAT_SETTLE_NS  = 1000;
  localparam int BAT_SETTLE_CYC = (BAT_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef struct packed {
    logic       write_lock;
    logic       read_hold;
    logic       freq_test_enable;
    logic       alarm_irq_enable;
    logic       alarm_backup_enable;
    logic       watchdog_steering;
    logic [4:0] watchdog_multiplier;
    logic [1:0] watchdog_resolution;
    logic       century_toggle_enable;
    logic       century_marker;
  } rbc_ctl_type;

  typedef struct packed {
    logic              chip_en_n;
    logic              write_en_n;
    logic              out_en_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } rbc_bus_type;

  typedef enum logic [2:0] {
    BC_IDLE   = 3'b001,
    BC_SETTLE = 3'b010,
    BC_SAMPLE = 3'b100
  } rbc_bc_state_type;

endpackage

// ===== logic/rbc_bat_check.sv
// Purpose: Battery check sequencer and battery weak flag
// Assumes: Inputs already synchronised to i_clk
// Notes:   Comparator is given a settle time before it is sampled
`timescale 1ns/1ps
module rbc_bat_check #(
  parameter int SETTLE_CYC = rbc_pkg::BAT_SETTLE_CYC
) (
  input  wire logic i_clk,
  input  wire logic i_reset,
  input  wire logic i_power_up,
  input  wire logic i_day_rollover,
  input  wire logic i_power_good,
  input  wire logic i_osc_running,
  input  wire logic i_cmp_low,
  output logic      o_battery_weak_flag
);
  import rbc_pkg::*;

  rbc_bc_state_type state_reg;
  rbc_bc_state_type state_next;
  logic [15:0]      count_reg;
  logic [15:0]      count_next;
  logic             flag_reg;
  logic             flag_next;
  logic             start;

  // Daily check needs oscillator; no check at all without main power
  assign start = i_power_good & (i_power_up | (i_day_rollover & i_osc_running));

  always_comb
  begin
    state_next = state_reg;
    count_next = count_reg;
    flag_next  = flag_reg;
    case (state_reg)
      BC_IDLE:
      begin
        if (start)
        begin
          state_next = BC_SETTLE;
          count_next = 16'(SETTLE_CYC - 1);
        end
      end
      BC_SETTLE:
      begin
        if (!i_power_good)
          state_next = BC_IDLE;
        else if (count_reg == 16'h0000)
          state_next = BC_SAMPLE;
        else
          count_next = count_reg - 16'h0001;
      end
      BC_SAMPLE:
      begin
        state_next = BC_IDLE;
        if (i_power_good)
          flag_next = i_cmp_low;
      end
      default:
        state_next = BC_IDLE;
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      state_reg <= BC_IDLE;
      count_reg <= 16'h0000;
      flag_reg  <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      count_reg <= count_next;
      flag_reg  <= flag_next;
    end
  end

  assign o_battery_weak_flag = flag_reg;

endmodule // rbc_bat_check

// ===== logic/rbc_top.sv
// Purpose: Battery check, century bit and control bit defaults behind the SRAM-style bus
// Assumes: Bus pins, supply sense, oscillator sense and comparator are asynchronous
// Notes:   Day and century rollover pulses come from timekeeping logic on i_clk
//          Supply events override a host write that lands in the same cycle
`timescale 1ns/1ps
module rbc_top #(
  parameter int SETTLE_CYC = rbc_pkg::BAT_SETTLE_CYC
) (
  input  wire logic                          i_clk,
  input  wire logic                          i_reset,
  input  wire rbc_pkg::rbc_bus_type          i_bus,
  input  wire logic                          i_power_good,
  input  wire logic                          i_osc_running,
  input  wire logic                          i_battery_cmp_low,
  input  wire logic                          i_day_rollover,
  input  wire logic                          i_century_rollover,
  output logic [rbc_pkg::DATA_W-1:0]         o_data,
  output logic                               o_data_oe,
  output logic                               o_battery_weak_flag,
  output rbc_pkg::rbc_ctl_type               o_ctl
);
  import rbc_pkg::*;

  // Pin synchronisers
  rbc_bus_type       bus_meta_reg;
  rbc_bus_type       bus_sync_reg;
  logic              pg_meta_reg;
  logic              pg_sync_reg;
  logic              osc_meta_reg;
  logic              osc_sync_reg;
  logic              cmp_meta_reg;
  logic              cmp_sync_reg;

  // Next values of the synchronisers
  rbc_bus_type       bus_meta_next;
  rbc_bus_type       bus_sync_next;
  logic              pg_meta_next;
  logic              pg_sync_next;
  logic              osc_meta_next;
  logic              osc_sync_next;
  logic              cmp_meta_next;
  logic              cmp_sync_next;

  // Edge detection and write capture
  logic              pg_prev_reg;
  logic              pg_prev_next;
  logic              we_prev_reg;
  logic              we_prev_next;
  logic [ADDR_W-1:0] waddr_reg;
  logic [ADDR_W-1:0] waddr_next;
  logic [DATA_W-1:0] wdata_reg;
  logic [DATA_W-1:0] wdata_next;

  // Control bits and read port
  rbc_ctl_type       ctl_reg;
  rbc_ctl_type       ctl_next;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic              rdata_oe_reg;
  logic              rdata_oe_next;

  logic              power_up;
  logic              power_down;
  logic              bus_selected;
  logic              write_strobe;
  logic              read_active;
  logic              battery_flag;

  // Bits cleared on every power-up and on reset; others are left alone
  function automatic rbc_ctl_type power_up_clear(input rbc_ctl_type c);
    rbc_ctl_type r;
    r                     = c;
    r.write_lock          = 1'b0;
    r.read_hold           = 1'b0;
    r.freq_test_enable    = 1'b0;
    r.alarm_irq_enable    = 1'b0;
    r.alarm_backup_enable = 1'b0;
    r.watchdog_steering   = 1'b0;
    r.watchdog_multiplier = 5'h00;
    r.watchdog_resolution = 2'h0;
    return r;
  endfunction

  // Power-down leaves alarm enables as they were
  function automatic rbc_ctl_type power_down_clear(input rbc_ctl_type c);
    rbc_ctl_type r;
    r                     = c;
    r.write_lock          = 1'b0;
    r.read_hold           = 1'b0;
    r.freq_test_enable    = 1'b0;
    r.watchdog_steering   = 1'b0;
    r.watchdog_multiplier = 5'h00;
    r.watchdog_resolution = 2'h0;
    return r;
  endfunction

  // Register read mux; unmapped and unused bits read as zero
  function automatic logic [DATA_W-1:0] read_word(
    input logic [ADDR_W-1:0] a,
    input rbc_ctl_type       c,
    input logic              batt
  );
    logic [DATA_W-1:0] w;
    w = DATA_RESET;
    case (a)
      FLAGS_ADDR:
        w[BATT_FLAG_BIT] = batt;
      ALARM_EN_ADDR:
      begin
        w[ALARM_IRQ_BIT]  = c.alarm_irq_enable;
        w[ALARM_BKUP_BIT] = c.alarm_backup_enable;
      end
      WATCHDOG_ADDR:
      begin
        w[WD_STEER_BIT]              = c.watchdog_steering;
        w[WD_MULT_LSB+4:WD_MULT_LSB] = c.watchdog_multiplier;
        w[WD_RES_LSB+1:WD_RES_LSB]   = c.watchdog_resolution;
      end
      CONTROL_ADDR:
      begin
        w[WRITE_LOCK_BIT] = c.write_lock;
        w[READ_HOLD_BIT]  = c.read_hold;
      end
      CLOCK_CTL_ADDR:
      begin
        w[FREQ_TEST_BIT]  = c.freq_test_enable;
        w[CENTURY_EN_BIT] = c.century_toggle_enable;
        w[CENTURY_BIT]    = c.century_marker;
      end
      default:
        w = DATA_RESET;
    endcase
    return w;
  endfunction

  // Host write into the control bits; century bit only behind write-lock
  function automatic rbc_ctl_type write_word(
    input rbc_ctl_type       c,
    input logic              lock,
    input logic [ADDR_W-1:0] a,
    input logic [DATA_W-1:0] d
  );
    rbc_ctl_type r;
    r = c;
    case (a)
      ALARM_EN_ADDR:
      begin
        r.alarm_irq_enable    = d[ALARM_IRQ_BIT];
        r.alarm_backup_enable = d[ALARM_BKUP_BIT];
      end
      WATCHDOG_ADDR:
      begin
        r.watchdog_steering   = d[WD_STEER_BIT];
        r.watchdog_multiplier = d[WD_MULT_LSB+4:WD_MULT_LSB];
        r.watchdog_resolution = d[WD_RES_LSB+1:WD_RES_LSB];
      end
      CONTROL_ADDR:
      begin
        r.write_lock = d[WRITE_LOCK_BIT];
        r.read_hold  = d[READ_HOLD_BIT];
      end
      CLOCK_CTL_ADDR:
      begin
        r.freq_test_enable      = d[FREQ_TEST_BIT];
        r.century_toggle_enable = d[CENTURY_EN_BIT];
        // Lock is the value before this write, so one write cannot unlock and set
        if (lock)
          r.century_marker = d[CENTURY_BIT];
      end
      default:
        r = c;
    endcase
    return r;
  endfunction

  // Two-stage synchronisers for every asynchronous input
  // Bus fields may land a cycle apart; writes use the last cycle with the strobe low
  always_comb
  begin
    bus_meta_next = i_bus;
    bus_sync_next = bus_meta_reg;
    pg_meta_next  = i_power_good;
    pg_sync_next  = pg_meta_reg;
    osc_meta_next = i_osc_running;
    osc_sync_next = osc_meta_reg;
    cmp_meta_next = i_battery_cmp_low;
    cmp_sync_next = cmp_meta_reg;
  end

  always_ff @(posedge i_clk)
  begin
    bus_meta_reg <= bus_meta_next;
    bus_sync_reg <= bus_sync_next;
    pg_meta_reg  <= pg_meta_next;
    pg_sync_reg  <= pg_sync_next;
    osc_meta_reg <= osc_meta_next;
    osc_sync_reg <= osc_sync_next;
    cmp_meta_reg <= cmp_meta_next;
    cmp_sync_reg <= cmp_sync_next;
  end

  // pg_prev clears at reset so a supply already present counts as a power-up
  assign power_up     = pg_sync_reg & ~pg_prev_reg;
  assign power_down   = ~pg_sync_reg & pg_prev_reg;
  assign bus_selected = ~bus_sync_reg.chip_en_n & pg_sync_reg;
  // Write is taken at the end of the write strobe, with address and data caught while low
  assign write_strobe = bus_sync_reg.write_en_n & ~we_prev_reg & bus_selected;
  assign read_active  = bus_selected & bus_sync_reg.write_en_n & ~bus_sync_reg.out_en_n;

  always_comb
  begin
    pg_prev_next = pg_sync_reg;
    we_prev_next = bus_sync_reg.write_en_n | ~bus_selected;
    waddr_next   = waddr_reg;
    wdata_next   = wdata_reg;
    if (bus_selected && !bus_sync_reg.write_en_n)
    begin
      waddr_next = bus_sync_reg.addr;
      wdata_next = bus_sync_reg.data;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      pg_prev_reg <= 1'b0;
      we_prev_reg <= 1'b1;
      waddr_reg   <= '0;
      wdata_reg   <= DATA_RESET;
    end
    else
    begin
      pg_prev_reg <= pg_prev_next;
      we_prev_reg <= we_prev_next;
      waddr_reg   <= waddr_next;
      wdata_reg   <= wdata_next;
    end
  end

  // Control bits: rollover, then host write, then supply events override
  always_comb
  begin
    ctl_next = ctl_reg;
    if (i_century_rollover && ctl_reg.century_toggle_enable)
      ctl_next.century_marker = ~ctl_reg.century_marker;
    if (write_strobe)
      ctl_next = write_word(ctl_next, ctl_reg.write_lock, waddr_reg, wdata_reg);
    if (power_down)
      ctl_next = power_down_clear(ctl_next);
    else if (power_up)
      ctl_next = power_up_clear(ctl_next);
  end

  // Century bit and century toggle enable bit have no reset value on purpose
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      ctl_reg <= power_up_clear(ctl_reg);
    else
      ctl_reg <= ctl_next;
  end

  // Read port
  // Data falls back to zero when the read ends, so nothing stale stays on o_data
  always_comb
  begin
    rdata_oe_next = read_active;
    rdata_next    = DATA_RESET;
    if (read_active)
      rdata_next = read_word(bus_sync_reg.addr, ctl_reg, battery_flag);
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      rdata_reg    <= DATA_RESET;
      rdata_oe_reg <= 1'b0;
    end
    else
    begin
      rdata_reg    <= rdata_next;
      rdata_oe_reg <= rdata_oe_next;
    end
  end

  rbc_bat_check #(
    .SETTLE_CYC (SETTLE_CYC)
  ) u_bat_check (
    .i_clk               (i_clk),
    .i_reset             (i_reset),
    .i_power_up          (power_up),
    .i_day_rollover      (i_day_rollover),
    .i_power_good        (pg_sync_reg),
    .i_osc_running       (osc_sync_reg),
    .i_cmp_low           (cmp_sync_reg),
    .o_battery_weak_flag (battery_flag)
  );

  assign o_data              = rdata_reg;
  assign o_data_oe           = rdata_oe_reg;
  assign o_battery_weak_flag = battery_flag;
  assign o_ctl               = ctl_reg;

endmodule // rbc_top

// ===== testbench/rbc_host.sv
// Purpose: Host processor model on the SRAM-style bus
// Assumes: Pins change on the falling edge of i_clk
// Notes:   Write strobe held 4 cycles, read strobe 5; released data shows the inverse
`timescale 1ns/1ps
module rbc_host (
  input  wire logic                  i_clk,
  input  wire logic [7:0]            i_data,
  input  wire logic                  i_data_oe,
  output rbc_pkg::rbc_bus_type       o_bus
);
  import rbc_pkg::*;
  initial o_bus = '{1'h1, 1'h1, 1'h1, 13'h0, 8'h0};
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_bus = '{1'h0, 1'h0, 1'h1, a, d};
    repeat (4) @(negedge i_clk);
    o_bus.write_en_n = 1'h1;
    repeat (4) @(negedge i_clk);
    o_bus.chip_en_n = 1'h1;
    o_bus.data = ~d;
    // Keep chip enable high between transfers long enough to be seen
    repeat (3) @(negedge i_clk);
  endtask
  task automatic rd(input logic [12:0] a, output logic [8:0] q);
    @(negedge i_clk);
    o_bus = '{1'h0, 1'h1, 1'h0, a, ~o_bus.data};
    repeat (5) @(negedge i_clk);
    q = {i_data_oe, i_data};
    o_bus.chip_en_n = 1'h1;
    o_bus.out_en_n = 1'h1;
    repeat (4) @(negedge i_clk);
  endtask
endmodule // rbc_host

// ===== testbench/rbc_chk.sv
// Purpose: Port-level checker for supply events, battery flag and century bit
// Assumes: Comparator input held steady around each check
// Notes:   Attached to rbc_top by bind
`timescale 1ns/1ps
module rbc_chk #(
  parameter int SETTLE_CYC = 4
) (
  input wire logic                   i_clk,
  input wire logic                   i_reset,
  input wire rbc_pkg::rbc_bus_type   i_bus,
  input wire logic                   i_power_good,
  input wire logic                   i_osc_running,
  input wire logic                   i_battery_cmp_low,
  input wire logic                   i_day_rollover,
  input wire logic                   i_century_rollover,
  input wire logic [7:0]             o_data,
  input wire logic                   o_data_oe,
  input wire logic                   o_battery_weak_flag,
  input wire rbc_pkg::rbc_ctl_type   o_ctl
);
  import rbc_pkg::*;
  logic pd_bits;
  // Bits that power-down must clear; alarm enables are left out
  assign pd_bits = o_ctl.write_lock | o_ctl.read_hold | o_ctl.freq_test_enable | o_ctl.watchdog_steering |
                   (|o_ctl.watchdog_multiplier) | (|o_ctl.watchdog_resolution);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);
  property p_pd_clear;
    $fell(i_power_good) |-> ##[1:6] !pd_bits;
  endproperty
  a_pd_clear: assert property (p_pd_clear) else $error("power-down left bits set");
  property p_pd_keep;
    $fell(i_power_good) && o_ctl.alarm_irq_enable |=> o_ctl.alarm_irq_enable [*5];
  endproperty
  a_pd_keep: assert property (p_pd_keep) else $error("alarm enable lost at power-down");
  property p_pu_clear;
    $rose(i_power_good) |-> ##[1:6] !pd_bits && !o_ctl.alarm_irq_enable && !o_ctl.alarm_backup_enable;
  endproperty
  a_pu_clear: assert property (p_pu_clear) else $error("power-up left bits set");
  property p_bkup;
    !i_power_good [*6] |-> $stable(o_battery_weak_flag);
  endproperty
  a_bkup: assert property (p_bkup) else $error("flag moved in back-up mode");
  // Pin passes two flops and the sample state, so the flag shows it three edges later
  property p_set;
    $rose(o_battery_weak_flag) |-> $past(i_battery_cmp_low, 3);
  endproperty
  a_set: assert property (p_set) else $error("flag set with good battery");
  property p_clr;
    $fell(o_battery_weak_flag) |-> !$past(i_battery_cmp_low, 3);
  endproperty
  a_clr: assert property (p_clr) else $error("flag cleared with weak battery");
  property p_cen_tog;
    i_century_rollover && o_ctl.century_toggle_enable |=> o_ctl.century_marker != $past(o_ctl.century_marker);
  endproperty
  a_cen_tog: assert property (p_cen_tog) else $error("century bit did not toggle");
  property p_cen_hold;
    i_century_rollover && !o_ctl.century_toggle_enable |=> $stable(o_ctl.century_marker);
  endproperty
  a_cen_hold: assert property (p_cen_hold) else $error("century bit toggled while disabled");
  property p_cen_lock;
    $changed(o_ctl.century_marker) && !$past(i_century_rollover) |-> $past(o_ctl.write_lock);
  endproperty
  a_cen_lock: assert property (p_cen_lock) else $error("century bit written unlocked");
endmodule // rbc_chk
bind rbc_top rbc_chk #(.SETTLE_CYC(SETTLE_CYC)) i_rbc_chk (
  .i_clk(i_clk), .i_reset(i_reset), .i_bus(i_bus), .i_power_good(i_power_good),
  .i_osc_running(i_osc_running), .i_battery_cmp_low(i_battery_cmp_low),
  .i_day_rollover(i_day_rollover), .i_century_rollover(i_century_rollover), .o_data(o_data),
  .o_data_oe(o_data_oe), .o_battery_weak_flag(o_battery_weak_flag), .o_ctl(o_ctl)
);

// ===== testbench/tb_top.sv
// Purpose: Self-checking bench for battery check, century bit and defaults
// Assumes: Inputs change on the falling edge; settle shortened to 4 cycles
// Notes:   Host model drives the bus pins
`timescale 1ns/1ps
module tb_top;
  import rbc_pkg::*;
  logic                 i_clk = 1'h0;
  logic                 i_reset = 1'h1;
  logic                 pg = 1'h1;
  logic                 osc = 1'h1;
  logic                 cmp = 1'h0;
  logic                 day = 1'h0;
  logic                 cen = 1'h0;
  rbc_bus_type          bus;
  logic [7:0]           dat;
  logic                 oe;
  logic                 flag;
  rbc_ctl_type          ctl;
  logic [8:0]           q;
  int                   num_errors = 0;
  int                   samples_checked = 0;
  always #2 i_clk = ~i_clk;
  rbc_host i_rbc_host (.i_clk(i_clk), .i_data(dat), .i_data_oe(oe), .o_bus(bus));
  rbc_top #(.SETTLE_CYC(4)) i_rbc_top (
    .i_clk(i_clk), .i_reset(i_reset), .i_bus(bus), .i_power_good(pg), .i_osc_running(osc),
    .i_battery_cmp_low(cmp), .i_day_rollover(day), .i_century_rollover(cen),
    .o_data(dat), .o_data_oe(oe), .o_battery_weak_flag(flag), .o_ctl(ctl)
  );
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("checked=%0d errors=%0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic pulse(input logic c);
    // Give synchronised supply and oscillator levels time to settle first
    repeat (4) @(negedge i_clk);
    if (c) cen = 1'h1;
    else day = 1'h1;
    @(negedge i_clk);
    cen = 1'h0;
    day = 1'h0;
    @(negedge i_clk);
  endtask
  task automatic settle;
    repeat (16) @(negedge i_clk);
  endtask
  task automatic t_defaults;
    settle();
    chk(ctl[14:2], 16'h0);
    chk(flag, 16'h0);
  endtask
  task automatic t_regs;
    i_rbc_host.wr(13'h1ff6, 8'ha0);
    i_rbc_host.wr(13'h1ff7, 8'hff);
    i_rbc_host.wr(13'h1ff8, 8'hc0);
    i_rbc_host.wr(13'h1ffc, 8'h40);
    chk(ctl[14:2], 16'h1fff);
    i_rbc_host.rd(13'h1ff7, q);
    chk(q, 16'h01ff);
    i_rbc_host.rd(13'h0100, q);
    chk(q[7:0], 16'h0);
  endtask
  task automatic t_century;
    i_rbc_host.wr(13'h1ffc, 8'h30);
    i_rbc_host.rd(13'h1ffc, q);
    chk(q, 16'h0130);
    pulse(1'h1);
    chk(ctl[1:0], 16'h2);
    i_rbc_host.wr(13'h1ffc, 8'h10);
    pulse(1'h1);
    chk(ctl[1:0], 16'h1);
    i_rbc_host.wr(13'h1ff8, 8'h00);
    i_rbc_host.wr(13'h1ffc, 8'h20);
    chk(ctl[1:0], 16'h3);
  endtask
  task automatic t_battery;
    cmp = 1'h1;
    pulse(1'h0);
    settle();
    chk(flag, 16'h1);
    i_rbc_host.rd(13'h1ff0, q);
    chk(q, 16'h0110);
    cmp = 1'h0;
    osc = 1'h0;
    pulse(1'h0);
    settle();
    chk(flag, 16'h1);
    osc = 1'h1;
    pulse(1'h0);
    settle();
    chk(flag, 16'h0);
    cmp = 1'h1;
    settle();
    chk(flag, 16'h0);
  endtask
  task automatic t_power;
    i_rbc_host.wr(13'h1ff8, 8'hc0);
    i_rbc_host.wr(13'h1ff6, 8'ha0);
    i_rbc_host.wr(13'h1ff7, 8'h85);
    i_rbc_host.wr(13'h1ffc, 8'h70);
    pg = 1'h0;
    settle();
    chk(ctl[14:2], 16'h0300);
    pulse(1'h0);
    settle();
    chk(flag, 16'h0);
    i_rbc_host.rd(13'h1ff8, q);
    chk(q, 16'h0);
    pg = 1'h1;
    settle();
    chk(ctl[14:2], 16'h0);
    chk(ctl[1:0], 16'h3);
    chk(flag, 16'h1);
  endtask
  initial
  begin
    repeat (20000) @(posedge i_clk);
    num_errors++;
    test_done();
  end
  initial
  begin
    repeat (16) @(negedge i_clk);
    i_reset = 1'h0;
    t_defaults();
    t_regs();
    t_century();
    t_battery();
    t_power();
    test_done();
  end
endmodule // tb_top
